/* File: logic/rctc_top.sv */
// Reset sequencing, clock-domain enables and board-test control.
// Assumes all pin inputs are synchronous to CLK; RESETN is power-up reset.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module rctc_top
    import rctc_pkg::*;
#(
    parameter int WAKE_COUNT = WAKE_CYCLES,
    parameter int HOLD_COUNT = HOLD_CYCLES
)
(
    // Clock, reset and enable
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Supplies, host reset and straps
    input wire logic MAIN_SUPPLY_ON,
    input wire logic STANDBY_SUPPLY_ON,
    input wire logic HOST_RESET_N,
    input wire logic FLOAT_STRAP_N,
    input wire logic XOR_STRAP_N,
    // XOR chain pins, index 0 first in chain
    input wire logic [XOR_PINS-1:0] CHAIN_PINS,
    output logic XOR_OUT,
    output logic PINS_FLOAT,
    // Reset actions toward other modules
    output logic HW_RESET_PULSE,
    output logic SW_RESET_PULSE,
    output logic LOCK_CLEAR,
    output logic PIN_DEFAULT_LOAD,
    output logic LDEV_RESET,
    output logic [GPIO_W-1:0] GPIO_DATA,
    output logic [CFG_W-1:0] MAIN_CFG,
    // Clock-domain enables and ticks
    output logic BUS_DOMAIN_EN,
    output logic LEGACY_CLK_EN,
    output logic STANDBY_CLK_EN,
    output logic HEALTH_TICK,
    output logic SLOW32_TICK,
    output logic HEALTH_READY,
    output logic CLOCK_VALID
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic host_rst_q;
    logic [CNT_W-1:0] hold_cnt_q;
    logic hold_ok_q;
    logic [CNT_W-1:0] wake_cnt_q;
    logic lock_q;
    logic [GPIO_W-1:0] gpio_flag_q;
    logic [1:0] pin_sel_q;
    logic [7:0] hdiv_q;
    logic [9:0] sdiv_q;
    logic first_main_q;
    rctc_mode_t mode_q;
    logic apb_acc;
    logic apb_wr;
    logic soft_reset_request_wr;
    logic hw_rel;
    logic [31:0] rd_mux;

    // Register hit test, used by the write paths
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    assign apb_acc = PSEL && PENABLE && !PREADY;
    assign apb_wr = apb_acc && PWRITE;
    assign soft_reset_request_wr = apb_wr && reg_hit(PADDR, ADDR_CTRL) && PWDATA[CTRL_SOFT_RESET_REQUEST_BIT];
    // Power-up release counts as hardware release
    assign hw_rel = !host_rst_q && HOST_RESET_N && MAIN_SUPPLY_ON;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Register port answers with one wait state
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else if (CE)
        begin
            PREADY <= apb_acc;
            PSLVERR <= apb_acc && (PADDR > ADDR_MAIN_CFG || PADDR[1:0] != 2'h0);
            PRDATA <= (apb_acc && !PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    // Read data selection, unmapped reads give zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (PADDR)
            ADDR_CTRL:
            begin
                rd_mux[CTRL_LOCK_BIT] = lock_q;
                rd_mux[3:2] = pin_sel_q; // Source select reads back
            end
            ADDR_STATUS:
            begin
                rd_mux[ST_CLOCK_VALID_FLAG_BIT] = CLOCK_VALID;
                rd_mux[ST_FLOAT_BIT] = mode_q == TM_FLOAT;
                rd_mux[ST_XOR_BIT] = mode_q == TM_XOR;
                rd_mux[ST_HEALTH_BIT] = HEALTH_READY;
                rd_mux[ST_STBYCLK_BIT] = STANDBY_CLK_EN;
            end
            ADDR_GPIO_FLAG: rd_mux[GPIO_W-1:0] = gpio_flag_q;
            ADDR_GPIO_DATA: rd_mux[GPIO_W-1:0] = GPIO_DATA;
            ADDR_MAIN_CFG: rd_mux[CFG_W-1:0] = MAIN_CFG;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Host reset tracking and hold timer
    // ****************************************************************
    // Previous level of the host reset pin and hold time measure
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            host_rst_q <= 1'b0;
            hold_cnt_q <= '0;
            hold_ok_q <= 1'b0;
        end
        else if (CE)
        begin
            host_rst_q <= HOST_RESET_N;
            if (HOST_RESET_N)
            begin
                hold_cnt_q <= '0;
                hold_ok_q <= hold_ok_q && !hw_rel ? 1'b0 : hold_ok_q;
            end
            else if (hold_cnt_q >= CNT_W'(HOLD_COUNT - 1))
            begin
                hold_ok_q <= 1'b1;
            end
            else
            begin
                hold_cnt_q <= hold_cnt_q + 1'b1;
                hold_ok_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Reset action pulses
    // ****************************************************************
    // Hardware release drives both pulses; write starts software reset
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            HW_RESET_PULSE <= 1'b0;
            SW_RESET_PULSE <= 1'b0;
            LOCK_CLEAR <= 1'b0;
            PIN_DEFAULT_LOAD <= 1'b0;
            LDEV_RESET <= 1'b0;
        end
        else if (CE)
        begin
            HW_RESET_PULSE <= hw_rel;
            SW_RESET_PULSE <= hw_rel || soft_reset_request_wr;
            // Lock clear pulse on hardware reset
            LOCK_CLEAR <= hw_rel;
            PIN_DEFAULT_LOAD <= hw_rel;
            // Logical devices reset with software reset
            LDEV_RESET <= hw_rel || soft_reset_request_wr;
        end
    end

    // ****************************************************************
    // Lock bit and configuration registers
    // ****************************************************************
    // Lock set by software, cleared by hardware reset
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            lock_q <= 1'b0;
        end
        else if (CE)
        begin
            if (LOCK_CLEAR)
            begin
                lock_q <= 1'b0;
            end
            else if (apb_wr && reg_hit(PADDR, ADDR_CTRL) && PWDATA[CTRL_LOCK_BIT])
            begin
                lock_q <= 1'b1;
            end
        end
    end

    // Main configuration reloads only while unlocked
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            MAIN_CFG <= MAIN_CFG_RST;
        end
        else if (CE)
        begin
            if (SW_RESET_PULSE && !lock_q)
            begin
                MAIN_CFG <= MAIN_CFG_RST;
            end
            else if (apb_wr && reg_hit(PADDR, ADDR_MAIN_CFG) && !lock_q)
            begin
                MAIN_CFG <= PWDATA[CFG_W-1:0];
            end
        end
    end

    // Flag survives software reset; flagged data bits reload
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            gpio_flag_q <= GPIO_FLAG_RST;
            GPIO_DATA <= GPIO_DATA_RST;
        end
        else if (CE)
        begin
            if (apb_wr && reg_hit(PADDR, ADDR_GPIO_FLAG) && !lock_q)
            begin
                gpio_flag_q <= PWDATA[GPIO_W-1:0];
            end
            if (SW_RESET_PULSE && !lock_q)
            begin
                GPIO_DATA <= (GPIO_DATA & ~gpio_flag_q) | (GPIO_DATA_RST & gpio_flag_q);
            end
            else if (apb_wr && reg_hit(PADDR, ADDR_GPIO_DATA) && !lock_q)
            begin
                GPIO_DATA <= PWDATA[GPIO_W-1:0];
            end
        end
    end

    // Module register source selection back to default
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            pin_sel_q <= PIN_SEL_RST;
        end
        else if (CE)
        begin
            if (SW_RESET_PULSE)
            begin
                pin_sel_q <= PIN_SEL_RST;
            end
            else if (apb_wr && reg_hit(PADDR, ADDR_CTRL))
            begin
                pin_sel_q <= PWDATA[3:2];
            end
        end
    end

    // ****************************************************************
    // Clock domains
    // ****************************************************************
    // Main-supply domains follow the main supply
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            BUS_DOMAIN_EN <= 1'b0;
            LEGACY_CLK_EN <= 1'b0;
        end
        else if (CE)
        begin
            BUS_DOMAIN_EN <= MAIN_SUPPLY_ON;
            LEGACY_CLK_EN <= MAIN_SUPPLY_ON;
        end
    end

    // Standby clocks start after first main power-up
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            first_main_q <= 1'b0;
            STANDBY_CLK_EN <= 1'b0;
            HEALTH_READY <= 1'b0;
        end
        else if (CE)
        begin
            if (!STANDBY_SUPPLY_ON)
            begin
                first_main_q <= 1'b0;
            end
            else if (MAIN_SUPPLY_ON)
            begin
                first_main_q <= 1'b1;
            end
            STANDBY_CLK_EN <= first_main_q && STANDBY_SUPPLY_ON;
            // Health usable once standby clocks run
            HEALTH_READY <= first_main_q && STANDBY_SUPPLY_ON;
        end
    end

    // Fixed dividers for slow health and 32 KHz ticks
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            hdiv_q <= '0;
            sdiv_q <= '0;
            HEALTH_TICK <= 1'b0;
            SLOW32_TICK <= 1'b0;
        end
        else if (CE)
        begin
            HEALTH_TICK <= 1'b0;
            SLOW32_TICK <= 1'b0;
            if (!STANDBY_CLK_EN)
            begin
                hdiv_q <= '0;
            end
            else if (hdiv_q == 8'(HEALTH_DIV - 1))
            begin
                hdiv_q <= '0;
                HEALTH_TICK <= 1'b1;
            end
            else
            begin
                hdiv_q <= hdiv_q + 1'b1;
            end
            // 32 KHz runs whenever standby supply is on
            if (!STANDBY_SUPPLY_ON)
            begin
                sdiv_q <= '0;
            end
            else if (sdiv_q == 10'(SLOW32_DIV - 1))
            begin
                sdiv_q <= '0;
                SLOW32_TICK <= 1'b1;
            end
            else
            begin
                sdiv_q <= sdiv_q + 1'b1;
            end
        end
    end

    // Clock valid within the wake time after reset release
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            wake_cnt_q <= '0;
            CLOCK_VALID <= 1'b0;
        end
        else if (CE)
        begin
            if (!HOST_RESET_N || !MAIN_SUPPLY_ON)
            begin
                wake_cnt_q <= '0;
                CLOCK_VALID <= 1'b0;
            end
            else if (wake_cnt_q == CNT_W'(WAKE_COUNT - 1))
            begin
                CLOCK_VALID <= 1'b1;
            end
            else
            begin
                wake_cnt_q <= wake_cnt_q + 1'b1;
            end
        end
    end

    // ****************************************************************
    // Board test modes
    // ****************************************************************
    // Straps latched at reset release, held until main or standby power drops
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            mode_q <= TM_NORMAL;
        end
        else if (CE)
        begin
            if (!MAIN_SUPPLY_ON || !STANDBY_SUPPLY_ON)
            begin
                mode_q <= TM_NORMAL;
            end
            else if (hw_rel && hold_ok_q && mode_q == TM_NORMAL)
            begin
                // Float strap low, XOR strap open
                if (!FLOAT_STRAP_N && XOR_STRAP_N)
                begin
                    mode_q <= TM_FLOAT;
                end
                // XOR strap low, float strap open
                else if (FLOAT_STRAP_N && !XOR_STRAP_N)
                begin
                    mode_q <= TM_XOR;
                end
            end
        end
    end

    // Chain pins are inputs; index order ends at output
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            XOR_OUT <= 1'b0;
            PINS_FLOAT <= 1'b0;
        end
        else if (CE)
        begin
            XOR_OUT <= (mode_q == TM_XOR) ? ^CHAIN_PINS : 1'b0;
            PINS_FLOAT <= mode_q == TM_FLOAT;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    a_hw_sw_pair: assert property (HW_RESET_PULSE |-> SW_RESET_PULSE && LOCK_CLEAR)
        else $error("hardware reset without software reset");
    a_soft_reset_request_start: assert property (CE && soft_reset_request_wr |=> SW_RESET_PULSE)
        else $error("soft reset request not started");
    a_lock_clear: assert property (CE && LOCK_CLEAR |=> !lock_q)
        else $error("lock not cleared");
    a_pin_default: assert property (CE && hw_rel |=> PIN_DEFAULT_LOAD && LDEV_RESET)
        else $error("pin default load missing");
    a_cfg_locked: assert property (CE && SW_RESET_PULSE && lock_q && !LOCK_CLEAR
        |=> $stable(MAIN_CFG))
        else $error("locked config changed");
    a_cfg_default: assert property (CE && SW_RESET_PULSE && !lock_q
        |=> MAIN_CFG == MAIN_CFG_RST)
        else $error("config not defaulted");
    a_flag_kept: assert property (CE && SW_RESET_PULSE && !apb_wr |=> $stable(gpio_flag_q))
        else $error("gpio flag touched by soft reset");
    a_legacy_off: assert property (CE && !MAIN_SUPPLY_ON |=> !LEGACY_CLK_EN && !BUS_DOMAIN_EN)
        else $error("main domain active without main supply");
    a_health_wait: assert property (CE && !STANDBY_CLK_EN |=> !HEALTH_TICK)
        else $error("health tick before first main power");
    a_clock_valid_flag_drop: assert property (CE && !HOST_RESET_N |=> !CLOCK_VALID)
        else $error("clock valid during host reset");
    a_float_mode: assert property (mode_q == TM_FLOAT && CE |=> PINS_FLOAT)
        else $error("float mode not applied");
    a_xor_chain: assert property (mode_q == TM_XOR && CE |=> XOR_OUT == ^$past(CHAIN_PINS))
        else $error("xor output wrong");
    a_mode_hold: assert property (CE && mode_q != TM_NORMAL && MAIN_SUPPLY_ON
        && STANDBY_SUPPLY_ON |=> $stable(mode_q))
        else $error("test mode not held");

    c_soft_reset: cover property (soft_reset_request_wr ##1 SW_RESET_PULSE);
    c_hw_reset: cover property (hw_rel ##1 HW_RESET_PULSE);
    c_float_entry: cover property (mode_q == TM_NORMAL ##1 mode_q == TM_FLOAT);
    c_xor_entry: cover property (mode_q == TM_NORMAL ##1 mode_q == TM_XOR);

endmodule // rctc_top

/* File: logic/rctc_pkg.sv */
// Constants for the reset, clock-domain and board-test controller.
// Assumes a single 20 MHz system clock and an APB register port.
package rctc_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 20000000;
    localparam int CLK_PERIOD_NS = 50;
    // Longest clock generator wake time, in microseconds
    localparam int WAKE_TIME_US = 33000;
    // Least host reset hold for test entry, in microseconds
    localparam int STRAP_HOLD_US = 10000;
    // Wake time rounds down, hold time rounds up
    localparam int WAKE_CYCLES = (WAKE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int HOLD_CYCLES = (STRAP_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Fixed dividers for the slow health clock and the 32 KHz domain
    localparam int HEALTH_HZ = 360000;
    localparam int SLOW32_HZ = 32768;
    localparam int HEALTH_DIV = CLK_HZ / HEALTH_HZ;
    localparam int SLOW32_DIV = CLK_HZ / SLOW32_HZ;
    localparam int CNT_W = 20;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_GPIO_FLAG = 8'h08;
    localparam logic [7:0] ADDR_GPIO_DATA = 8'h0C;
    localparam logic [7:0] ADDR_MAIN_CFG = 8'h10;

    // Control register fields
    localparam int CTRL_SOFT_RESET_REQUEST_BIT = 0;
    localparam int CTRL_LOCK_BIT = 1;
    // Status register fields
    localparam int ST_CLOCK_VALID_FLAG_BIT = 0;
    localparam int ST_FLOAT_BIT = 1;
    localparam int ST_XOR_BIT = 2;
    localparam int ST_HEALTH_BIT = 3;
    localparam int ST_STBYCLK_BIT = 4;

    // Widths and reset values
    localparam int GPIO_W = 16;
    localparam int CFG_W = 8;
    localparam int XOR_PINS = 16;
    localparam logic [GPIO_W-1:0] GPIO_FLAG_RST = 16'h0000;
    localparam logic [GPIO_W-1:0] GPIO_DATA_RST = 16'h0000;
    localparam logic [CFG_W-1:0] MAIN_CFG_RST = 8'h00;
    localparam logic [1:0] PIN_SEL_RST = 2'h0;

    // Test mode chosen from the straps
    typedef enum logic [1:0] {TM_NORMAL, TM_FLOAT, TM_XOR} rctc_mode_t;

endpackage

/* File: tb/rctc_host_model.sv */
// Host chipset and board tester model: supplies, host reset and straps.
// Assumes the bench calls its tasks from one process, clocked by CLK.
`timescale 1ns/10ps
module rctc_host_model
(
    // Clock
    input wire logic CLK,
    // Supplies, host reset and straps
    output logic MAIN_ON,
    output logic STBY_ON,
    output logic HOST_RESET_N,
    output logic FLOAT_N,
    output logic XOR_N
);
    // ****************************************************************
    // Power-on state: supplies up, host reset held, straps pulled up
    // ****************************************************************
    // bus clock runs before reset ends
    initial
    begin
        MAIN_ON = 1'b1;
        STBY_ON = 1'b1;
        HOST_RESET_N = 1'b0;
        FLOAT_N = 1'b1;
        XOR_N = 1'b1;
    end

    // Switch the supplies after a clock edge
    task automatic power(input logic m, input logic s);
        @(posedge CLK);
        MAIN_ON <= m;
        STBY_ON <= s;
    endtask

    // straps held through reset, then left open
    task automatic host_reset(input int n, input logic f, input logic x);
        @(posedge CLK);
        HOST_RESET_N <= 1'b0;
        FLOAT_N <= f;
        XOR_N <= x;
        repeat (n) @(posedge CLK);
        HOST_RESET_N <= 1'b1;
        // Release edge, pulse edge, then one edge for the pin outputs to settle
        repeat (3) @(posedge CLK);
        FLOAT_N <= 1'b1;
        XOR_N <= 1'b1;
    endtask
endmodule // rctc_host_model

/* File: tb/rctc_top_tb_top.sv */
// Self-checking bench for the reset, clock-domain and board-test controller.
// Assumes short wake and hold counts; host side comes from the host model.
`timescale 1ns/10ps
module rctc_top_tb_top;
    import rctc_pkg::*;
    localparam int WAKE = 20;
    localparam int HOLD = 8;
    logic CLK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [15:0] CHAIN_PINS = 16'h0000, GPIO_DATA;
    logic [7:0] MAIN_CFG;
    logic PREADY, PSLVERR, XOR_OUT, PINS_FLOAT, HW_RESET_PULSE, SW_RESET_PULSE, err;
    logic LOCK_CLEAR, PIN_DEFAULT_LOAD, LDEV_RESET, BUS_DOMAIN_EN, LEGACY_CLK_EN;
    logic STANDBY_CLK_EN, HEALTH_TICK, SLOW32_TICK, HEALTH_READY, CLOCK_VALID;
    logic main_on, stby_on, host_rst_n, float_n, xor_n;
    int error_cnt = 0, cmp_count = 0, hw_n = 0, sw_n = 0, ht_n = 0, st_n = 0, base;
    logic [15:0] chain_tab [4] = '{16'h0001, 16'h0003, 16'h8000, 16'hFFFE};

    // Clock generator, 50 ns period
    always #25 CLK = ~CLK;

    rctc_top #(.WAKE_COUNT(WAKE), .HOLD_COUNT(HOLD)) i_rctc_top (
        .CLK(CLK), .RESETN(RESETN), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .MAIN_SUPPLY_ON(main_on),
        .STANDBY_SUPPLY_ON(stby_on), .HOST_RESET_N(host_rst_n),
        .FLOAT_STRAP_N(float_n), .XOR_STRAP_N(xor_n), .CHAIN_PINS(CHAIN_PINS),
        .XOR_OUT(XOR_OUT), .PINS_FLOAT(PINS_FLOAT), .HW_RESET_PULSE(HW_RESET_PULSE),
        .SW_RESET_PULSE(SW_RESET_PULSE), .LOCK_CLEAR(LOCK_CLEAR),
        .PIN_DEFAULT_LOAD(PIN_DEFAULT_LOAD), .LDEV_RESET(LDEV_RESET),
        .GPIO_DATA(GPIO_DATA), .MAIN_CFG(MAIN_CFG), .BUS_DOMAIN_EN(BUS_DOMAIN_EN),
        .LEGACY_CLK_EN(LEGACY_CLK_EN), .STANDBY_CLK_EN(STANDBY_CLK_EN),
        .HEALTH_TICK(HEALTH_TICK), .SLOW32_TICK(SLOW32_TICK),
        .HEALTH_READY(HEALTH_READY), .CLOCK_VALID(CLOCK_VALID));

    rctc_host_model i_rctc_host_model (.CLK(CLK), .MAIN_ON(main_on), .STBY_ON(stby_on),
        .HOST_RESET_N(host_rst_n), .FLOAT_N(float_n), .XOR_N(xor_n));

    // Pulse counters, run on the falling edge so checks see settled counts
    always @(negedge CLK)
    begin
        if ((HW_RESET_PULSE & LOCK_CLEAR & PIN_DEFAULT_LOAD) === 1'b1) hw_n++;
        if ((SW_RESET_PULSE & LDEV_RESET) === 1'b1) sw_n++;
        if (HEALTH_TICK === 1'b1) ht_n++;
        if (SLOW32_TICK === 1'b1) st_n++;
    end

    // ****************************************************************
    // Bus tasks and checks
    // ****************************************************************
    // One APB transfer; waits for PREADY under a bounded count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1)
        begin
            error_cnt++;
            $display("Error at %0t: no bus answer", $time);
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // Compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        report_and_stop();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial
    begin
        repeat (8) @(posedge CLK);
        RESETN <= 1'b1;
        // Hardware reset release and clock valid timing
        i_rctc_host_model.host_reset(2, 1'b1, 1'b1);
        chk(hw_n, 1);
        chk(sw_n, 1);
        chk(CLOCK_VALID, 1'b0);
        repeat (WAKE + 3) @(posedge CLK);
        chk(CLOCK_VALID, 1'b1);
        apb(1'b0, ADDR_STATUS, 0);
        chk(rd, 32'h19);
        $display("Test hardware reset done");
        // Soft reset with flagged GPIO bits
        apb(1'b1, ADDR_GPIO_FLAG, 32'h00FF);
        apb(1'b1, ADDR_GPIO_DATA, 32'hABCD);
        apb(1'b1, ADDR_MAIN_CFG, 32'h5A);
        chk(MAIN_CFG, 8'h5A);
        apb(1'b1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge CLK);
        chk(sw_n, 2);
        chk(MAIN_CFG, 8'h00);
        chk(GPIO_DATA, 16'hAB00);
        apb(1'b0, ADDR_GPIO_FLAG, 0);
        chk(rd, 32'h00FF);
        $display("Test soft reset done");
        // Lock protects config; hardware reset clears the lock
        apb(1'b1, ADDR_MAIN_CFG, 32'h5A);
        apb(1'b1, ADDR_CTRL, 32'h2);
        apb(1'b1, ADDR_MAIN_CFG, 32'h33);
        apb(1'b1, ADDR_CTRL, 32'hF);
        repeat (3) @(posedge CLK);
        chk(MAIN_CFG, 8'h5A);
        apb(1'b0, ADDR_CTRL, 0);
        chk(rd, 32'h2);
        i_rctc_host_model.host_reset(2, 1'b1, 1'b1);
        apb(1'b0, ADDR_CTRL, 0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h14, 0);
        chk({rd[30:0], err}, 32'h1);
        $display("Test lock done");
        // Tick rates and supply-dependent domains
        base = ht_n;
        repeat (550) @(posedge CLK);
        chk(ht_n - base, 10);
        base = st_n;
        repeat (1220) @(posedge CLK);
        chk(st_n - base, 2);
        i_rctc_host_model.power(1'b0, 1'b1);
        repeat (3) @(posedge CLK);
        chk({BUS_DOMAIN_EN, LEGACY_CLK_EN, CLOCK_VALID}, 0);
        chk({STANDBY_CLK_EN, HEALTH_READY}, 3);
        i_rctc_host_model.power(1'b1, 1'b1);
        $display("Test clock domains done");
        // Float mode: short hold refused, full hold taken and kept
        i_rctc_host_model.host_reset(HOLD / 2, 1'b0, 1'b1);
        chk(PINS_FLOAT, 1'b0);
        i_rctc_host_model.host_reset(HOLD + 1, 1'b0, 1'b1);
        chk(PINS_FLOAT, 1'b1);
        i_rctc_host_model.host_reset(HOLD + 1, 1'b1, 1'b1);
        chk(PINS_FLOAT, 1'b1);
        // XOR chain mode after a supply cycle
        i_rctc_host_model.power(1'b0, 1'b1);
        i_rctc_host_model.power(1'b1, 1'b1);
        i_rctc_host_model.host_reset(HOLD + 1, 1'b1, 1'b0);
        chk(PINS_FLOAT, 1'b0);
        foreach (chain_tab[i])
        begin
            CHAIN_PINS <= chain_tab[i];
            repeat (2) @(posedge CLK);
            chk(XOR_OUT, ^chain_tab[i]);
        end
        $display("Test board modes done");
        report_and_stop();
    end
endmodule // rctc_top_tb_top
